// >>> hw/usfc_pkg.sv
`default_nettype none
package usfc_pkg;
  // ****************************************************
  // Register map
  // ****************************************************
  localparam logic [3:0] ADDR_FLAGS = 4'h0;
  localparam logic [3:0] ADDR_MASK = 4'h1;
  localparam logic [3:0] ADDR_EP0_IN_CFG = 4'h2;
  localparam logic [3:0] ADDR_EP0_OUT_CFG = 4'h3;
  localparam logic [3:0] ADDR_CTRL = 4'h4;
  localparam logic [3:0] ADDR_PWR = 4'h5;
  localparam logic [3:0] ADDR_STATUS = 4'h6;
  localparam logic [3:0] ADDR_IN_DATA = 4'h7;

  // ****************************************************
  // Field positions
  // ****************************************************
  localparam int FLAG_SETUP = 0;
  localparam int FLAG_IN_NAK = 1;
  localparam int FLAG_IN_SENT = 2;
  localparam int FLAG_ORPHAN = 3;
  localparam int NUM_FLAGS = 4;
  localparam int CFG_ENABLE = 0;
  localparam int CTRL_MODULE_EN = 0;
  localparam int PWR_BITS = 4;

  // ****************************************************
  // Reset values
  // ****************************************************
  localparam logic [3:0] RST_FLAGS = 4'h0;
  localparam logic [3:0] RST_MASK = 4'h0;
  localparam logic [7:0] RST_CFG = 8'h01;
  localparam logic [3:0] RST_PWR = 4'h0;
  localparam logic [15:0] RST_WORD = 16'h0000;

  // ****************************************************
  // Timing: clear hazard window around the token CRC
  // ****************************************************
  localparam int CLK_NS = 100;
  localparam int CRC_BIT_NS = 83;
  localparam int CRC_BIT_CYC = (CRC_BIT_NS + CLK_NS - 1) / CLK_NS;

  // ****************************************************
  // Host token kinds from the link decoder
  // ****************************************************
  localparam logic [1:0] TOK_NONE = 2'h0;
  localparam logic [1:0] TOK_SETUP = 2'h1;
  localparam logic [1:0] TOK_IN = 2'h2;
  localparam logic [1:0] TOK_OUT = 2'h3;

  // ****************************************************
  // Handshake answers
  // ****************************************************
  localparam logic [1:0] HS_NONE = 2'h0;
  localparam logic [1:0] HS_NAK = 2'h1;
  localparam logic [1:0] HS_DATA = 2'h2;
  localparam logic [1:0] HS_ORPHAN = 2'h3;

  typedef enum logic [1:0] {USFC_IDLE, USFC_WAIT_CRC, USFC_ANSWER} usfc_tok_state_t;
endpackage
`default_nettype wire

// >>> hw/usfc_clear_gate.sv
`default_nettype none
module usfc_clear_gate (
  input wire logic clk, // Module clock
  input wire logic rst, // Synchronous reset
  input wire logic clear_req, // Software clear of the setup flag
  input wire logic crc_busy, // Token CRC is on the bus
  input wire logic ep_en_in, // Endpoint zero IN enable
  input wire logic ep_en_out, // Endpoint zero OUT enable
  output logic clear_now, // Clear pulse applied to the flag
  output logic gated // Both endpoint zero enables are off
);
  logic pending;

  // ****************************************************
  // Clear scheduling
  // ****************************************************

  // With both endpoints gated, the clear is applied at once and token logic ignores it
  assign gated = !ep_en_in && !ep_en_out;

  // A live clear is held off until the token CRC has passed, closing the hazard window
  always_ff @(posedge clk) begin
    if (rst) begin
      pending <= 1'b0;
    end else if (clear_req && (crc_busy && !gated)) begin
      pending <= 1'b1;
    end else if (!crc_busy) begin
      pending <= 1'b0;
    end
  end

  // Clear applies when the CRC window is not open or the endpoint is gated
  assign clear_now = (clear_req || pending) && (!crc_busy || gated);
endmodule
`default_nettype wire

// >>> hw/usfc_top.sv
`default_nettype none
// How it works
// - SETUP sets flag and raises interrupt
// - IN tokens NAKed while flag set
// - Clear during token CRC never misbehaves
// - Module enable low resets transmit state
// - Gated endpoint isolates clear from IN
// - Gated sequence may emit orphan answers
// - Power control all-zero clears failed start
module usfc_top (
  input wire logic clk, // Module clock, 10 MHz
  input wire logic rst, // Synchronous reset, active high
  input wire logic [3:0] addr, // Register address
  input wire logic [15:0] wdata, // Register write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  output logic [15:0] rdata, // Read data, cycle after read strobe
  input wire logic [1:0] tok_kind, // Decoded host token, one-cycle pulse
  input wire logic tok_ep0, // Token addresses endpoint zero
  input wire logic crc_busy, // Token CRC bits on the bus
  output logic [1:0] hs_kind, // Answer to the host, one-cycle pulse
  output logic [7:0] tx_byte, // Data byte sent with a data answer
  output logic ldo_enable, // Bus regulators enabled
  output logic irq // Interrupt, level
);
  logic [usfc_pkg::NUM_FLAGS-1:0] flags;
  logic [usfc_pkg::NUM_FLAGS-1:0] mask;
  logic [usfc_pkg::NUM_FLAGS-1:0] next_flags;
  logic [usfc_pkg::NUM_FLAGS-1:0] set_ev;
  logic [7:0] ep0_in_config;
  logic [7:0] ep0_out_config;
  logic module_enable_bit;
  logic [usfc_pkg::PWR_BITS-1:0] usb_power_control;
  logic start_failed;
  logic [7:0] in_data;
  logic in_loaded;
  logic clear_req;
  logic clear_now;
  logic gated;
  logic gated_seen;
  logic soft_rst;
  usfc_pkg::usfc_tok_state_t state;
  usfc_pkg::usfc_tok_state_t next_state;

  // ****************************************************
  // Helpers
  // ****************************************************

  // Register select, used by the write paths; the read port decodes addr with a case
  function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
    hit = (a == r);
  endfunction

  // Module reset: hard reset or enable bit low
  assign soft_rst = rst || !module_enable_bit;
  assign clear_req = wr && hit(addr, usfc_pkg::ADDR_FLAGS) && !wdata[usfc_pkg::FLAG_SETUP];

  // ****************************************************
  // Clear gating
  // ****************************************************

  // Defers a live clear past the token CRC window
  usfc_clear_gate u_gate (
    .clk(clk),
    .rst(soft_rst),
    .clear_req(clear_req),
    .crc_busy(crc_busy),
    .ep_en_in(ep0_in_config[usfc_pkg::CFG_ENABLE]),
    .ep_en_out(ep0_out_config[usfc_pkg::CFG_ENABLE]),
    .clear_now(clear_now),
    .gated(gated)
  );

  // ****************************************************
  // Software registers
  // ****************************************************

  // Module enable bit survives its own reset
  always_ff @(posedge clk) begin
    if (rst) begin
      module_enable_bit <= 1'b0;
    end else if (wr && hit(addr, usfc_pkg::ADDR_CTRL)) begin
      module_enable_bit <= wdata[usfc_pkg::CTRL_MODULE_EN];
    end
  end

  // Power control: all-zero write turns regulators off and clears a failed start
  always_ff @(posedge clk) begin
    if (rst) begin
      usb_power_control <= usfc_pkg::RST_PWR;
      start_failed <= 1'b1;
    end else if (wr && hit(addr, usfc_pkg::ADDR_PWR)) begin
      usb_power_control <= wdata[usfc_pkg::PWR_BITS-1:0];
      if (wdata[usfc_pkg::PWR_BITS-1:0] == usfc_pkg::RST_PWR) begin
        start_failed <= 1'b0;
      end
    end
  end

  // Regulators run only when enabled and not stuck in a failed start
  always_ff @(posedge clk) begin
    if (rst) begin
      ldo_enable <= 1'b0;
    end else begin
      ldo_enable <= (usb_power_control != usfc_pkg::RST_PWR) && !start_failed;
    end
  end

  // Endpoint zero configurations and interrupt mask
  always_ff @(posedge clk) begin
    if (soft_rst) begin
      ep0_in_config <= usfc_pkg::RST_CFG;
      ep0_out_config <= usfc_pkg::RST_CFG;
      mask <= usfc_pkg::RST_MASK;
    end else if (wr) begin
      if (hit(addr, usfc_pkg::ADDR_EP0_IN_CFG)) begin
        ep0_in_config <= wdata[7:0];
      end
      if (hit(addr, usfc_pkg::ADDR_EP0_OUT_CFG)) begin
        ep0_out_config <= wdata[7:0];
      end
      if (hit(addr, usfc_pkg::ADDR_MASK)) begin
        mask <= wdata[usfc_pkg::NUM_FLAGS-1:0];
      end
    end
  end

  // IN data buffer, armed by a write and consumed by a data answer
  always_ff @(posedge clk) begin
    if (soft_rst) begin
      in_data <= 8'h00;
      in_loaded <= 1'b0;
    end else if (wr && hit(addr, usfc_pkg::ADDR_IN_DATA)) begin
      in_data <= wdata[7:0];
      in_loaded <= 1'b1;
    end else if (state == usfc_pkg::USFC_ANSWER && hs_kind == usfc_pkg::HS_DATA) begin
      in_loaded <= 1'b0;
    end
  end

  // Remembers that the gated clear happened, so re-enable sends an orphan
  always_ff @(posedge clk) begin
    if (soft_rst) begin
      gated_seen <= 1'b0;
    end else if (clear_now && gated) begin
      gated_seen <= 1'b1;
    end else if (!gated) begin
      gated_seen <= 1'b0;
    end
  end

  // ****************************************************
  // Token handling
  // ****************************************************

  // Answer decision: SETUP flag forces NAK, gated endpoint ignores tokens
  always_comb begin
    next_state = state;
    case (state)
      usfc_pkg::USFC_IDLE: begin
        if (tok_kind == usfc_pkg::TOK_IN && tok_ep0 && !gated) begin
          next_state = usfc_pkg::USFC_WAIT_CRC;
        end
      end
      usfc_pkg::USFC_WAIT_CRC: begin
        if (!crc_busy) begin
          next_state = usfc_pkg::USFC_ANSWER;
        end
      end
      usfc_pkg::USFC_ANSWER: begin
        next_state = usfc_pkg::USFC_IDLE; // One answer per token, never endless
      end
      default: begin
        next_state = usfc_pkg::USFC_IDLE;
      end
    endcase
  end

  // Token state register, cleared by module reset
  always_ff @(posedge clk) begin
    if (soft_rst) begin
      state <= usfc_pkg::USFC_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Handshake output and data byte
  always_ff @(posedge clk) begin
    if (soft_rst) begin
      hs_kind <= usfc_pkg::HS_NONE;
      tx_byte <= 8'h00;
    end else if (next_state == usfc_pkg::USFC_ANSWER) begin
      if (flags[usfc_pkg::FLAG_SETUP] || !in_loaded) begin
        hs_kind <= usfc_pkg::HS_NAK;
      end else begin
        hs_kind <= usfc_pkg::HS_DATA;
        tx_byte <= in_data;
      end
    end else if (gated_seen && !gated) begin
      hs_kind <= usfc_pkg::HS_ORPHAN;
    end else begin
      hs_kind <= usfc_pkg::HS_NONE;
    end
  end

  // ****************************************************
  // Interrupt flags
  // ****************************************************

  // Event pulses into the sticky flags
  always_comb begin
    set_ev = '0;
    set_ev[usfc_pkg::FLAG_SETUP] = (tok_kind == usfc_pkg::TOK_SETUP) && tok_ep0;
    set_ev[usfc_pkg::FLAG_IN_NAK] = (next_state == usfc_pkg::USFC_ANSWER) && flags[usfc_pkg::FLAG_SETUP];
    set_ev[usfc_pkg::FLAG_IN_SENT] = (next_state == usfc_pkg::USFC_ANSWER) && !flags[usfc_pkg::FLAG_SETUP]
      && in_loaded;
    set_ev[usfc_pkg::FLAG_ORPHAN] = gated_seen && !gated;
  end

  // Setup flag clears by writing zero; others clear by writing one; sets win
  always_comb begin
    next_flags = flags;
    if (clear_now) begin
      next_flags[usfc_pkg::FLAG_SETUP] = 1'b0;
    end
    if (wr && hit(addr, usfc_pkg::ADDR_FLAGS)) begin
      next_flags[usfc_pkg::NUM_FLAGS-1:1] = flags[usfc_pkg::NUM_FLAGS-1:1] & ~wdata[usfc_pkg::NUM_FLAGS-1:1];
    end
    next_flags = next_flags | set_ev;
  end

  // Flag register
  always_ff @(posedge clk) begin
    if (soft_rst) begin
      flags <= usfc_pkg::RST_FLAGS;
    end else begin
      flags <= next_flags;
    end
  end

  // Interrupt level from unmasked flags, registered
  always_ff @(posedge clk) begin
    if (soft_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(next_flags & mask);
    end
  end

  // ****************************************************
  // Read port
  // ****************************************************

  // Read data valid the cycle after the strobe only
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= usfc_pkg::RST_WORD;
    end else if (rd) begin
      case (addr)
        usfc_pkg::ADDR_FLAGS: rdata <= {12'h000, flags};
        usfc_pkg::ADDR_MASK: rdata <= {12'h000, mask};
        usfc_pkg::ADDR_EP0_IN_CFG: rdata <= {8'h00, ep0_in_config};
        usfc_pkg::ADDR_EP0_OUT_CFG: rdata <= {8'h00, ep0_out_config};
        usfc_pkg::ADDR_CTRL: rdata <= {15'h0000, module_enable_bit};
        usfc_pkg::ADDR_PWR: rdata <= {12'h000, usb_power_control};
        usfc_pkg::ADDR_STATUS: rdata <= {12'h000, in_loaded, start_failed, ldo_enable, gated};
        usfc_pkg::ADDR_IN_DATA: rdata <= {8'h00, in_data};
        default: rdata <= usfc_pkg::RST_WORD;
      endcase
    end else begin
      rdata <= usfc_pkg::RST_WORD;
    end
  end
endmodule
`default_nettype wire

// >>> testbench/usfc_assertions.sv
`default_nettype none
module usfc_assertions (
  input wire logic clk, // Clock
  input wire logic rst, // Reset
  input wire logic [3:0] addr, // Address
  input wire logic [15:0] wdata, // Write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  input wire logic [15:0] rdata, // Read data
  input wire logic [1:0] tok_kind, // Host token
  input wire logic tok_ep0, // Endpoint zero
  input wire logic crc_busy, // Token CRC busy
  input wire logic [1:0] hs_kind, // Answer
  input wire logic [7:0] tx_byte, // Answer byte
  input wire logic ldo_enable, // Regulators on
  input wire logic irq // Interrupt
);
  timeunit 1ns;
  timeprecision 1ns;
  logic en_q; // Module enabled
  logic mask0; // Setup interrupt unmasked
  logic in_pend; // IN token awaits an answer
  logic fresh; // Setup seen, flag not cleared yet
  logic pwr_clr; // Failed start cleared
  logic [7:0] last_byte; // Last loaded IN byte
  logic ans; // NAK or data answer
  logic setup_tok; // Setup token taken
  logic wr_en; // Write while enabled
  // Answer and strobe decodes
  assign ans = (hs_kind == usfc_pkg::HS_NAK) || (hs_kind == usfc_pkg::HS_DATA);
  assign setup_tok = (tok_kind == usfc_pkg::TOK_SETUP) && tok_ep0 && en_q;
  assign wr_en = wr && en_q;
  // ****************************************************
  // Shadow of the state implied at the ports
  // ****************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      en_q <= 1'b0;
      mask0 <= 1'b0;
      in_pend <= 1'b0;
      fresh <= 1'b0;
      pwr_clr <= 1'b0;
      last_byte <= 8'h00;
    end else if (wr && addr == usfc_pkg::ADDR_CTRL && !wdata[0]) begin
      en_q <= 1'b0;
      mask0 <= 1'b0;
      fresh <= 1'b0;
      in_pend <= 1'b0;
    end else begin
      if (wr && addr == usfc_pkg::ADDR_CTRL) en_q <= 1'b1;
      if (wr && addr == usfc_pkg::ADDR_PWR && wdata[3:0] == 4'h0) pwr_clr <= 1'b1;
      if (wr_en && addr == usfc_pkg::ADDR_MASK) mask0 <= wdata[0];
      if (wr_en && addr == usfc_pkg::ADDR_IN_DATA) last_byte <= wdata[7:0];
      if (setup_tok) fresh <= 1'b1;
      else if (wr_en && addr == usfc_pkg::ADDR_FLAGS && !wdata[0]) fresh <= 1'b0;
      if (tok_kind == usfc_pkg::TOK_IN && tok_ep0) in_pend <= 1'b1;
      else if (ans) in_pend <= 1'b0;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  AST_SETUP_IRQ: assert property (setup_tok && mask0 |-> ##[1:2] irq)
    else $error("setup token did not raise the interrupt");
  AST_NAK_WHILE_SET: assert property (fresh |-> hs_kind != usfc_pkg::HS_DATA)
    else $error("data sent while setup flag set");
  AST_ANSWER_HAS_TOKEN: assert property (ans |-> in_pend)
    else $error("answer without an IN token");
  AST_NO_ANSWER_IN_CRC: assert property ($past(crc_busy) |-> !ans)
    else $error("answer while token CRC busy");
  AST_SINGLE_ANSWER: assert property (ans |=> (hs_kind == usfc_pkg::HS_NONE) [*2])
    else $error("answer repeated");
  AST_DATA_BYTE: assert property (hs_kind == usfc_pkg::HS_DATA |-> tx_byte == last_byte)
    else $error("wrong data byte");
  AST_LDO_OFF: assert property (wr && addr == usfc_pkg::ADDR_PWR && wdata[3:0] == 4'h0 |-> ##[1:2] !ldo_enable)
    else $error("regulators stayed on");
  AST_LDO_ON: assert property (wr && addr == usfc_pkg::ADDR_PWR && wdata[3:0] != 4'h0 && pwr_clr
    |-> ##[1:2] ldo_enable)
    else $error("regulators did not restart");
  AST_DISABLED_QUIET: assert property (!$past(en_q) |-> hs_kind == usfc_pkg::HS_NONE && !irq)
    else $error("activity while module disabled");
endmodule
bind usfc_top usfc_assertions u_chk (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .tok_kind(tok_kind), .tok_ep0(tok_ep0), .crc_busy(crc_busy), .hs_kind(hs_kind),
  .tx_byte(tx_byte), .ldo_enable(ldo_enable), .irq(irq));
`default_nettype wire

// >>> testbench/usfc_host_model.sv
`default_nettype none
module usfc_host_model (
  input wire logic clk, // Clock
  output logic [1:0] tok_kind, // Token pulse
  output logic tok_ep0, // Token for endpoint zero
  output logic crc_busy // Token CRC on the bus
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle bus at time zero
  initial begin
    tok_kind = usfc_pkg::TOK_NONE;
    tok_ep0 = 1'b0;
    crc_busy = 1'b0;
  end
  // One token, CRC busy for crc_n cycles, endpoint line inverted after
  task automatic token(input logic [1:0] kind, input logic ep0, input int crc_n);
    @(posedge clk);
    tok_kind <= kind;
    tok_ep0 <= ep0;
    crc_busy <= (crc_n > 0);
    @(posedge clk);
    tok_kind <= usfc_pkg::TOK_NONE;
    tok_ep0 <= !ep0;
    repeat (crc_n - 1) @(posedge clk);
    crc_busy <= 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> testbench/usfc_top_tb.sv
`default_nettype none
module usfc_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0; // Clock
  logic rst = 1'b1; // Reset
  logic [3:0] addr = 4'h0; // Address
  logic [15:0] wdata = 16'h0000; // Write data
  logic wr = 1'b0; // Write strobe
  logic rd = 1'b0; // Read strobe
  logic [15:0] rdata, v, n0; // Read data, scratch
  logic [1:0] tok_kind, hs_kind, last_hs; // Token, answer
  logic tok_ep0, crc_busy, ldo_enable, irq; // Link and status
  logic [7:0] tx_byte, last_tx; // Answer byte
  logic [15:0] n_ans = 16'h0000; // Answers seen
  logic [15:0] exp_rst [8]; // Reset values
  int miscompares = 0;
  int checks = 0;
  // 10 MHz clock
  always #50 clk = ~clk;
  usfc_host_model host (.clk(clk), .tok_kind(tok_kind), .tok_ep0(tok_ep0), .crc_busy(crc_busy));
  usfc_top DUT (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .tok_kind(tok_kind), .tok_ep0(tok_ep0), .crc_busy(crc_busy), .hs_kind(hs_kind), .tx_byte(tx_byte),
    .ldo_enable(ldo_enable), .irq(irq));
  // Record every answer pulse
  always @(posedge clk) begin
    if (!rst && hs_kind !== usfc_pkg::HS_NONE) begin
      n_ans <= n_ans + 16'h0001;
      last_hs <= hs_kind;
      last_tx <= tx_byte;
    end
  end
  task automatic results();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic wait_ans(input logic [15:0] n_old);
    for (int i = 0; i < 40 && n_ans === n_old; i++) @(posedge clk) #1;
    if (n_ans === n_old) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, n_ans, n_old + 16'h0001);
      results();
    end
  endtask
  task automatic in_tok(input int crc_n, input logic [1:0] kind, input logic [7:0] b);
    n0 = n_ans;
    host.token(usfc_pkg::TOK_IN, 1'b1, crc_n);
    wait_ans(n0);
    chk({14'h0, last_hs}, {14'h0, kind});
    if (kind == usfc_pkg::HS_DATA) chk({8'h00, last_tx}, {8'h00, b});
  endtask
  task automatic setup_tok();
    host.token(usfc_pkg::TOK_SETUP, 1'b1, 0);
    repeat (2) @(posedge clk);
  endtask
  // Main sequence
  initial begin
    exp_rst = '{16'h0, 16'h0, 16'h0001, 16'h0001, 16'h0, 16'h0, 16'h0004, 16'h0};
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    wr_reg(4'h8, 16'hffff);
    for (int i = 0; i < 8; i++) begin
      rd_reg(i == 7 ? 4'h8 : 4'(i), v);
      chk(v, exp_rst[i]);
    end
    wr_reg(usfc_pkg::ADDR_CTRL, 16'h0001);
    wr_reg(usfc_pkg::ADDR_PWR, 16'h000f);
    chk({15'h0, ldo_enable}, 16'h0000);
    wr_reg(usfc_pkg::ADDR_PWR, 16'h0000);
    wr_reg(usfc_pkg::ADDR_PWR, 16'h0003);
    rd_reg(usfc_pkg::ADDR_STATUS, v);
    chk(v, 16'h0002);
    chk({15'h0, ldo_enable}, 16'h0001);
    $display("test power done");
    wr_reg(usfc_pkg::ADDR_MASK, 16'h0001);
    setup_tok();
    chk({15'h0, irq}, 16'h0001);
    in_tok(0, usfc_pkg::HS_NAK, 8'h00);
    rd_reg(usfc_pkg::ADDR_FLAGS, v);
    chk(v, 16'h0003);
    wr_reg(usfc_pkg::ADDR_IN_DATA, 16'h005a);
    in_tok(0, usfc_pkg::HS_NAK, 8'h00);
    wr_reg(usfc_pkg::ADDR_FLAGS, 16'h0000);
    rd_reg(usfc_pkg::ADDR_FLAGS, v);
    chk(v, 16'h0002);
    wr_reg(usfc_pkg::ADDR_FLAGS, 16'h0002);
    rd_reg(usfc_pkg::ADDR_FLAGS, v);
    chk({v[14:0], irq}, 16'h0000);
    in_tok(0, usfc_pkg::HS_DATA, 8'h5a);
    $display("test setup done");
    wr_reg(usfc_pkg::ADDR_FLAGS, 16'h000f);
    setup_tok();
    wr_reg(usfc_pkg::ADDR_IN_DATA, 16'h003c);
    n0 = n_ans;
    fork
      host.token(usfc_pkg::TOK_IN, 1'b1, 3);
      begin
        @(posedge clk);
        wr_reg(usfc_pkg::ADDR_FLAGS, 16'h0000);
      end
    join
    repeat (25) @(posedge clk);
    chk(n_ans, n0 + 16'h0001);
    rd_reg(usfc_pkg::ADDR_FLAGS, v);
    chk(v & 16'h0001, 16'h0000);
    $display("test crc clear done");
    wr_reg(usfc_pkg::ADDR_FLAGS, 16'h000f);
    setup_tok();
    wr_reg(usfc_pkg::ADDR_IN_DATA, 16'h0077);
    wr_reg(usfc_pkg::ADDR_EP0_IN_CFG, 16'h0000);
    wr_reg(usfc_pkg::ADDR_EP0_OUT_CFG, 16'h0000);
    n0 = n_ans;
    host.token(usfc_pkg::TOK_IN, 1'b1, 2);
    repeat (8) @(posedge clk);
    chk(n_ans, n0);
    wr_reg(usfc_pkg::ADDR_FLAGS, 16'h0000);
    rd_reg(usfc_pkg::ADDR_FLAGS, v);
    chk(v & 16'h0001, 16'h0000);
    n0 = n_ans;
    wr_reg(usfc_pkg::ADDR_EP0_IN_CFG, 16'h0001);
    wait_ans(n0);
    chk({14'h0, last_hs}, {14'h0, usfc_pkg::HS_ORPHAN});
    rd_reg(usfc_pkg::ADDR_FLAGS, v);
    chk(v & 16'h0008, 16'h0008);
    wr_reg(usfc_pkg::ADDR_EP0_OUT_CFG, 16'h0001);
    repeat (3) @(posedge clk);
    in_tok(0, usfc_pkg::HS_DATA, 8'h77);
    $display("test gated clear done");
    setup_tok();
    wr_reg(usfc_pkg::ADDR_CTRL, 16'h0000);
    repeat (2) @(posedge clk);
    chk({15'h0, irq}, 16'h0000);
    wr_reg(usfc_pkg::ADDR_MASK, 16'h0001);
    wr_reg(usfc_pkg::ADDR_CTRL, 16'h0001);
    rd_reg(usfc_pkg::ADDR_MASK, v);
    chk(v, 16'h0000);
    rd_reg(usfc_pkg::ADDR_FLAGS, v);
    chk(v, 16'h0000);
    in_tok(0, usfc_pkg::HS_NAK, 8'h00);
    $display("test module reset done");
    results();
  end
endmodule
`default_nettype wire
